// ==== hw/data_transfer_branch_exec.sv ====
// How it works
// - Overflow set: branch to pc plus offset plus one
// - Overflow clear: branch, flags untouched, one/two cycles
// - Interrupts enabled: relative branch, flags untouched
// - Interrupts disabled: relative branch, one/two cycles
// - Indirect load two cycles, optional post-increment
// - Pre-decrement load: decrement, then read
// - Displacement load, second/third pointer, pointer kept
// - Direct load from instruction address, two cycles
// - Indirect store two cycles, optional post-increment
// - Pre-decrement store: decrement, then write
// - Displacement store, second/third pointer, pointer kept
// - Direct store to instruction address, two cycles
// - Program memory read via third pointer, three cycles
`timescale 1ns/10ps
`default_nettype none

module data_transfer_branch_exec
    import exec_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Operation issue
    input wire logic op_valid,
    output logic op_ready,
    input wire op_t op_code,
    input wire logic [4:0] dst_idx,
    input wire logic [4:0] src_idx,
    input wire logic [7:0] imm_byte,
    input wire logic [6:0] br_offset,
    input wire ptr_sel_t ptr_sel,
    input wire ptr_mode_t ptr_mode,
    input wire logic [5:0] disp,
    input wire logic [15:0] direct_addr,
    input wire logic use_register_zero,
    // Status flags from the core
    input wire logic flag_overflow,
    input wire logic flag_irq_enable,
    // Data memory
    output logic [15:0] dm_addr,
    output logic [7:0] dm_wdata,
    output logic dm_we,
    output logic dm_re,
    input wire logic [7:0] dm_rdata,
    // Program memory
    output logic [15:0] pm_addr,
    output logic pm_re,
    input wire logic [7:0] pm_rdata,
    output logic pm_we,
    output logic [15:0] pm_wdata,
    input wire logic pm_busy,
    // Observation
    output logic [15:0] pc,
    input wire logic [4:0] peek_idx,
    output logic [7:0] peek_data
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Low register of the selected pointer pair
    function automatic logic [4:0] ptr_lo_idx(input ptr_sel_t sel);
        case (sel)
            PTR_FIRST: ptr_lo_idx = PTR_FIRST_LO_IDX;
            PTR_SECOND: ptr_lo_idx = PTR_SECOND_LO_IDX;
            default: ptr_lo_idx = PTR_THIRD_LO_IDX;
        endcase
    endfunction : ptr_lo_idx

    ////////////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0] rf_q [REG_COUNT]; // General-purpose registers
    state_t state_q; // Sequencer
    state_t state_d;
    logic [15:0] pc_q; // Program counter
    logic [15:0] pc_d;
    logic [4:0] dst_q; // Destination held for the write-back cycle (second for data loads, third for program reads)
    logic [15:0] addr_q; // Memory address held for the access cycle
    logic [7:0] wdata_q; // Store byte
    logic load_q; // Access cycle is a read
    logic dm_re_q;
    logic dm_we_q;
    logic pm_re_q;
    logic pm_we_q;
    logic [15:0] pm_wdata_q;
    logic [7:0] peek_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode

    logic issue; // Operation taken this cycle
    logic is_branch;
    logic taken;
    logic is_ind; // Pointer-based data access
    logic is_disp;
    logic is_direct;
    logic is_dload;
    logic is_dstore;
    logic is_pm;
    ptr_sel_t eff_sel;
    logic [4:0] plo;
    logic [15:0] ptr_value;
    logic use_disp;
    logic [15:0] eff_addr;
    logic [15:0] ptr_next;
    logic ptr_write;
    logic ptr_we;
    logic [15:0] mem_addr;
    logic [15:0] br_target;
    logic [15:0] pc_plus;

    assign op_ready = (state_q == ST_IDLE);
    assign issue = op_valid && op_ready;
    assign is_branch = (op_code == OP_BRANCH_OVERFLOW_SET) || (op_code == OP_BRANCH_OVERFLOW_CLEAR)
        || (op_code == OP_BRANCH_IRQ_ENABLED) || (op_code == OP_BRANCH_IRQ_DISABLED);
    // Branch conditions on the two flags
    assign taken = ((op_code == OP_BRANCH_OVERFLOW_SET) && flag_overflow)
        || ((op_code == OP_BRANCH_OVERFLOW_CLEAR) && !flag_overflow)
        || ((op_code == OP_BRANCH_IRQ_ENABLED) && flag_irq_enable)
        || ((op_code == OP_BRANCH_IRQ_DISABLED) && !flag_irq_enable);
    assign is_disp = (op_code == OP_DISPLACEMENT_LOAD) || (op_code == OP_DISPLACEMENT_STORE);
    assign is_ind = (op_code == OP_INDIRECT_LOAD) || (op_code == OP_INDIRECT_STORE) || is_disp;
    assign is_direct = (op_code == OP_DIRECT_LOAD) || (op_code == OP_DIRECT_STORE);
    assign is_dload = (op_code == OP_INDIRECT_LOAD) || (op_code == OP_DISPLACEMENT_LOAD)
        || (op_code == OP_DIRECT_LOAD);
    assign is_dstore = (op_code == OP_INDIRECT_STORE) || (op_code == OP_DISPLACEMENT_STORE)
        || (op_code == OP_DIRECT_STORE);
    assign is_pm = (op_code == OP_PROGRAM_MEMORY_READ) || (op_code == OP_PROGRAM_MEMORY_WRITE);

    // Program memory always goes through the third pointer
    assign eff_sel = is_pm ? PTR_THIRD : ptr_sel;
    assign plo = ptr_lo_idx(eff_sel);
    assign ptr_value = {rf_q[plo | 5'h01], rf_q[plo]};
    // First pointer has no displacement form
    assign use_disp = is_disp && (ptr_sel != PTR_FIRST);

    ptr_addr_gen u_ptr_addr_gen (
        .ptr_value(ptr_value),
        .ptr_mode(ptr_mode),
        .use_disp(use_disp),
        .disp(disp),
        .eff_addr(eff_addr),
        .ptr_next(ptr_next),
        .ptr_write(ptr_write)
    );

    // Pointer written back at issue; program memory read only post-increments
    // A displacement form never moves its pointer, whatever the mode input says
    assign ptr_we = issue && ((is_ind && !is_disp && ptr_write)
        || ((op_code == OP_PROGRAM_MEMORY_READ) && (ptr_mode == PM_POST_INC)));
    assign mem_addr = is_direct ? direct_addr : eff_addr;
    assign pc_plus = pc_q + PC_STEP;
    assign br_target = pc_plus + {{9{br_offset[6]}}, br_offset};

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer

    // Next state and program counter
    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        case (state_q)
            ST_IDLE: begin
                if (issue) begin
                    pc_d = pc_plus;
                    if (is_branch && taken) begin
                        pc_d = br_target;
                        state_d = ST_BRANCH;
                    end else if (is_ind || is_direct) begin
                        state_d = ST_MEM;
                    end else if (op_code == OP_PROGRAM_MEMORY_READ) begin
                        state_d = ST_PM_ADDR;
                    end else if (op_code == OP_PROGRAM_MEMORY_WRITE) begin
                        state_d = ST_PM_WRITE;
                    end
                end
            end
            // Second cycle of a taken branch
            ST_BRANCH: state_d = ST_IDLE;
            // Data memory access cycle
            ST_MEM: state_d = ST_IDLE;
            // Program memory address cycle, then data cycle
            ST_PM_ADDR: state_d = ST_PM_DATA;
            ST_PM_DATA: state_d = ST_IDLE;
            // Hold until program memory reports the write done
            ST_PM_WRITE: begin
                if (!pm_we_q && !pm_busy) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            pc_q <= PC_RESET;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Memory requests

    // Request strobes are registered and last exactly one cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dst_q <= REGISTER_ZERO_IDX;
            addr_q <= 16'h0000;
            wdata_q <= REG_RESET;
            load_q <= 1'b0;
            dm_re_q <= 1'b0;
            dm_we_q <= 1'b0;
            pm_re_q <= 1'b0;
            pm_we_q <= 1'b0;
            pm_wdata_q <= 16'h0000;
        end else begin
            dm_re_q <= issue && is_dload;
            dm_we_q <= issue && is_dstore;
            pm_re_q <= issue && (op_code == OP_PROGRAM_MEMORY_READ);
            pm_we_q <= issue && (op_code == OP_PROGRAM_MEMORY_WRITE);
            if (issue) begin
                load_q <= is_dload;
                addr_q <= is_pm ? ptr_value : mem_addr;
                wdata_q <= rf_q[src_idx];
                pm_wdata_q <= {rf_q[REGISTER_ONE_IDX], rf_q[REGISTER_ZERO_IDX]};
                // Program memory read with no operand lands in register zero
                dst_q <= ((op_code == OP_PROGRAM_MEMORY_READ) && use_register_zero)
                    ? REGISTER_ZERO_IDX : dst_idx;
            end
        end
    end

    assign dm_addr = addr_q;
    assign dm_wdata = wdata_q;
    assign dm_re = dm_re_q;
    assign dm_we = dm_we_q;
    assign pm_addr = addr_q;
    assign pm_re = pm_re_q;
    assign pm_we = pm_we_q;
    assign pm_wdata = pm_wdata_q;
    assign pc = pc_q;
    assign peek_data = peek_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Register file

    logic byte_we; // Single-register write
    logic [4:0] byte_idx;
    logic [7:0] byte_val;
    logic pair_we; // Two-register copy
    logic [4:0] pair_dst;
    logic [4:0] pair_src;

    assign pair_we = issue && (op_code == OP_REGISTER_PAIR_COPY);
    assign pair_dst = {dst_idx[4:1], 1'b0};
    assign pair_src = {src_idx[4:1], 1'b0};

    // Byte write source: issue-cycle moves, or data returned from memory
    always_comb begin
        byte_we = 1'b0;
        byte_idx = dst_q;
        byte_val = dm_rdata;
        if (issue && (op_code == OP_REGISTER_MOVE)) begin
            byte_we = 1'b1;
            byte_idx = dst_idx;
            byte_val = rf_q[src_idx];
        end else if (issue && (op_code == OP_IMMEDIATE_LOAD)) begin
            byte_we = 1'b1;
            byte_idx = dst_idx;
            byte_val = imm_byte;
        end else if ((state_q == ST_MEM) && load_q) begin
            byte_we = 1'b1;
        end else if (state_q == ST_PM_DATA) begin
            byte_we = 1'b1;
            byte_val = pm_rdata;
        end
    end

    // Register writes; a memory byte written back wins over a pointer update
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                rf_q[i] <= REG_RESET;
            end
            peek_q <= REG_RESET;
        end else begin
            peek_q <= rf_q[peek_idx];
            if (ptr_we) begin
                rf_q[plo] <= ptr_next[7:0];
                rf_q[plo | 5'h01] <= ptr_next[15:8];
            end
            if (pair_we) begin
                rf_q[pair_dst] <= rf_q[pair_src];
                rf_q[pair_dst | 5'h01] <= rf_q[pair_src | 5'h01];
            end
            if (byte_we) begin
                rf_q[byte_idx] <= byte_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_issue(op_t o);
        issue && (op_code == o);
    endsequence

    sequence s_two_cycle;
        !op_ready ##1 op_ready;
    endsequence

    chk_overflow_set_jump: assert property (
        s_issue(OP_BRANCH_OVERFLOW_SET) and (flag_overflow && 1'b1)
        |=> (pc_q == $past(br_target)) && !op_ready ##1 op_ready)
        else $error("overflow-set branch target or timing wrong");
    chk_overflow_clear_jump: assert property (
        s_issue(OP_BRANCH_OVERFLOW_CLEAR) and (!flag_overflow && 1'b1)
        |=> pc_q == $past(pc_q) + {{9{$past(br_offset[6])}}, $past(br_offset)} + PC_STEP)
        else $error("overflow-clear branch target wrong");
    chk_irq_enabled_jump: assert property (
        s_issue(OP_BRANCH_IRQ_ENABLED) |=> pc_q == ($past(flag_irq_enable)
            ? $past(br_target) : $past(pc_plus)))
        else $error("irq-enabled branch target wrong");
    chk_irq_disabled_time: assert property (
        s_issue(OP_BRANCH_IRQ_DISABLED) and (flag_irq_enable && 1'b1)
        |=> op_ready && (pc_q == $past(pc_plus)))
        else $error("irq-disabled branch not taken yet slowed");
    chk_load_two_cycle: assert property (
        s_issue(OP_INDIRECT_LOAD) |=> (dm_re and s_two_cycle))
        else $error("indirect load does not take two cycles");
    chk_pre_dec_addr: assert property (
        issue && is_ind && !is_disp && (ptr_mode == PM_PRE_DEC)
        |=> dm_addr == $past(ptr_value) - PTR_STEP)
        else $error("pre-decrement address wrong");
    chk_disp_keeps_ptr: assert property (
        issue && is_disp && (ptr_sel != PTR_FIRST) |-> !ptr_we ##1 dm_addr == $past(ptr_value)
            + {10'h000, $past(disp)})
        else $error("displacement access moved pointer or wrong address");
    chk_direct_store: assert property (
        s_issue(OP_DIRECT_STORE) |=> dm_we && (dm_addr == $past(direct_addr)) ##1 !dm_we)
        else $error("direct store strobe or address wrong");
    chk_pm_read_three: assert property (
        s_issue(OP_PROGRAM_MEMORY_READ) |=> pm_re ##1 !pm_re && !op_ready ##1 op_ready)
        else $error("program memory read does not take three cycles");
    chk_move_one_cycle: assert property (
        issue && ((op_code == OP_REGISTER_MOVE) || (op_code == OP_IMMEDIATE_LOAD))
        |=> op_ready && rf_q[$past(dst_idx)] == $past(byte_val))
        else $error("single-cycle move wrong");
    chk_ptr_wrap: assert property (
        ptr_we && (ptr_value == 16'hffff) && (ptr_mode == PM_POST_INC)
        |=> {rf_q[$past(plo) | 5'h01], rf_q[$past(plo)]} == 16'h0000)
        else $error("pointer increment does not wrap");

endmodule : data_transfer_branch_exec

`default_nettype wire

// ==== hw/exec_pkg.sv ====
package exec_pkg;

    // Register file shape
    localparam int REG_COUNT = 32;
    localparam int REG_IDX_W = 5;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int BR_OFFSET_W = 7;
    localparam int DISP_W = 6;

    // Low register of each pointer pair, the high byte sits one above
    localparam logic [4:0] PTR_FIRST_LO_IDX = 5'h1a;
    localparam logic [4:0] PTR_SECOND_LO_IDX = 5'h1c;
    localparam logic [4:0] PTR_THIRD_LO_IDX = 5'h1e;
    localparam logic [4:0] REGISTER_ZERO_IDX = 5'h00;
    localparam logic [4:0] REGISTER_ONE_IDX = 5'h01;

    // Reset values and step sizes
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [15:0] PTR_STEP = 16'h0001;

    // Operations handled by this unit
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_BRANCH_OVERFLOW_SET = 4'h1,
        OP_BRANCH_OVERFLOW_CLEAR = 4'h2,
        OP_BRANCH_IRQ_ENABLED = 4'h3,
        OP_BRANCH_IRQ_DISABLED = 4'h4,
        OP_REGISTER_MOVE = 4'h5,
        OP_REGISTER_PAIR_COPY = 4'h6,
        OP_IMMEDIATE_LOAD = 4'h7,
        OP_INDIRECT_LOAD = 4'h8,
        OP_DISPLACEMENT_LOAD = 4'h9,
        OP_DIRECT_LOAD = 4'ha,
        OP_INDIRECT_STORE = 4'hb,
        OP_DISPLACEMENT_STORE = 4'hc,
        OP_DIRECT_STORE = 4'hd,
        OP_PROGRAM_MEMORY_READ = 4'he,
        OP_PROGRAM_MEMORY_WRITE = 4'hf
    } op_t;

    // Pointer choice
    typedef enum logic [1:0] {
        PTR_FIRST = 2'h0,
        PTR_SECOND = 2'h1,
        PTR_THIRD = 2'h2
    } ptr_sel_t;

    // Pointer adjustment
    typedef enum logic [1:0] {
        PM_PLAIN = 2'h0,
        PM_POST_INC = 2'h1,
        PM_PRE_DEC = 2'h2
    } ptr_mode_t;

    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_BRANCH = 6'h02,
        ST_MEM = 6'h04,
        ST_PM_ADDR = 6'h08,
        ST_PM_DATA = 6'h10,
        ST_PM_WRITE = 6'h20
    } state_t;

endpackage : exec_pkg

// ==== hw/ptr_addr_gen.sv ====
`timescale 1ns/10ps
`default_nettype none

// Effective address and pointer update for indirect accesses
module ptr_addr_gen
    import exec_pkg::*;
(
    // Pointer in
    input wire logic [15:0] ptr_value,
    input wire ptr_mode_t ptr_mode,
    input wire logic use_disp,
    input wire logic [5:0] disp,
    // Results
    output logic [15:0] eff_addr,
    output logic [15:0] ptr_next,
    output logic ptr_write
);

    logic [15:0] ptr_plus; // Full 16-bit wrap both ways
    logic [15:0] ptr_minus;
    logic [15:0] ptr_disp;

    assign ptr_plus = ptr_value + PTR_STEP;
    assign ptr_minus = ptr_value - PTR_STEP;
    assign ptr_disp = ptr_value + {10'h000, disp};

    // Displacement leaves the pointer alone; pre-decrement uses the new value
    assign eff_addr = use_disp ? ptr_disp : ((ptr_mode == PM_PRE_DEC) ? ptr_minus : ptr_value);
    assign ptr_next = (ptr_mode == PM_PRE_DEC) ? ptr_minus : ptr_plus;
    assign ptr_write = !use_disp && (ptr_mode != PM_PLAIN);

endmodule : ptr_addr_gen

`default_nettype wire

// ==== testbench/data_transfer_branch_exec_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module data_transfer_branch_exec_tb
    import exec_pkg::*;
;
    localparam int PM_BUSY = 3; // Program write busy length of the model
    logic sys_clk, rst, op_valid, op_ready, use_register_zero, flag_overflow, flag_irq_enable;
    op_t op_code;
    ptr_sel_t ptr_sel;
    ptr_mode_t ptr_mode;
    logic [4:0] dst_idx, src_idx, peek_idx;
    logic [7:0] imm_byte, dm_wdata, dm_rdata, pm_rdata, peek_data, pv, s_wd;
    logic [6:0] br_offset;
    logic [5:0] disp;
    logic [15:0] direct_addr, dm_addr, pm_addr, pm_wdata, pc, cyc, s_dadr, s_padr, s_pwd;
    logic [15:0] exp_pc, jmp;
    logic dm_we, dm_re, pm_re, pm_we, pm_busy, s_re, s_we, s_pre, s_pwe;
    int err_count = 0;
    int num_checks = 0;
    int tick = 0;

    data_transfer_branch_exec u_dut (.sys_clk(sys_clk), .rst(rst), .op_valid(op_valid),
        .op_ready(op_ready), .op_code(op_code), .dst_idx(dst_idx), .src_idx(src_idx),
        .imm_byte(imm_byte), .br_offset(br_offset), .ptr_sel(ptr_sel), .ptr_mode(ptr_mode),
        .disp(disp), .direct_addr(direct_addr), .use_register_zero(use_register_zero),
        .flag_overflow(flag_overflow), .flag_irq_enable(flag_irq_enable), .dm_addr(dm_addr),
        .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re), .dm_rdata(dm_rdata),
        .pm_addr(pm_addr), .pm_re(pm_re), .pm_rdata(pm_rdata), .pm_we(pm_we),
        .pm_wdata(pm_wdata), .pm_busy(pm_busy), .pc(pc), .peek_idx(peek_idx),
        .peek_data(peek_data));
    mem_model #(.PM_BUSY(PM_BUSY)) u_mem (.sys_clk(sys_clk), .rst(rst), .dm_addr(dm_addr),
        .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re), .dm_rdata(dm_rdata),
        .pm_addr(pm_addr), .pm_re(pm_re), .pm_we(pm_we), .pm_rdata(pm_rdata),
        .pm_busy(pm_busy));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        tick++;
        if (tick == 5000) begin
            err_count++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic conclude;
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Offer one operation, hold it until taken, record the first cycle, wait for idle
    task automatic issue(input op_t op, input logic [4:0] d, input logic [4:0] s,
                         input logic [7:0] k);
        op_code = op;
        dst_idx = d;
        src_idx = s;
        imm_byte = k;
        op_valid = 1'b1;
        while (op_ready !== 1'b1) begin
            @(posedge sys_clk);
            #1;
        end
        @(posedge sys_clk);
        #1;
        op_valid = 1'b0;
        {s_re, s_we, s_pre, s_pwe} = {dm_re, dm_we, pm_re, pm_we};
        {s_dadr, s_padr, s_pwd, s_wd} = {dm_addr, pm_addr, pm_wdata, dm_wdata};
        cyc = 16'h0001;
        while (op_ready !== 1'b1 && cyc < 16'h0028) begin
            @(posedge sys_clk);
            #1;
            cyc++;
        end
        // A single-cycle op lets one edge pass so the strobe is not reassigned at once
        if (cyc == 16'h0001) begin
            @(posedge sys_clk);
            #1;
        end
        exp_pc = exp_pc + 16'h0001 + jmp;
        jmp = 16'h0000;
        check("pc", pc, exp_pc);
    endtask : issue

    task automatic immediate_load(input logic [4:0] d, input logic [7:0] k);
        issue(OP_IMMEDIATE_LOAD, d, 5'h00, k);
    endtask : immediate_load

    task automatic peek(input logic [4:0] i);
        peek_idx = i;
        @(posedge sys_clk);
        #1;
        pv = peek_data;
    endtask : peek

    task automatic set_ptr(input logic [4:0] lo, input logic [15:0] p);
        immediate_load(lo, p[7:0]);
        immediate_load(lo + 5'h01, p[15:8]);
    endtask : set_ptr

    task automatic check_ptr(input logic [4:0] lo, input logic [15:0] exp);
        peek(lo);
        check("pointer low", {8'h00, pv}, {8'h00, exp[7:0]});
        peek(lo + 5'h01);
        check("pointer high", {8'h00, pv}, {8'h00, exp[15:8]});
    endtask : check_ptr

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_branch;
        op_t ops [4];
        logic tk;
        ops = '{OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IRQ_ENABLED,
                OP_BRANCH_IRQ_DISABLED};
        for (int i = 0; i < 8; i++) begin
            // The unrelated flag is set opposite so a swapped flag shows
            flag_overflow = (i < 4) ? i[0] : ~i[0];
            flag_irq_enable = (i < 4) ? ~i[0] : i[0];
            br_offset = i[0] ? 7'h7d : 7'h06;
            tk = i[1] ? ~i[0] : i[0];
            jmp = tk ? {{9{br_offset[6]}}, br_offset} : 16'h0000;
            issue(ops[i / 2], 5'h00, 5'h00, 8'h00);
            check("branch cycles", cyc, tk ? 16'h0002 : 16'h0001);
        end
    endtask : t_branch

    task automatic t_move;
        immediate_load(5'h10, 8'ha5);
        issue(OP_REGISTER_MOVE, 5'h11, 5'h10, 8'h00);
        check("move cycles", cyc, 16'h0001);
        immediate_load(5'h12, 8'h3c);
        immediate_load(5'h13, 8'hc3);
        issue(OP_REGISTER_PAIR_COPY, 5'h14, 5'h12, 8'h00);
        check("copy cycles", cyc, 16'h0001);
        peek(5'h11);
        check("move", {8'h00, pv}, 16'h00a5);
        peek(5'h14);
        check("copy low", {8'h00, pv}, 16'h003c);
        peek(5'h15);
        check("copy high", {8'h00, pv}, 16'h00c3);
    endtask : t_move

    task automatic t_mem(input logic st, input op_t op, input ptr_sel_t sel,
                         input ptr_mode_t md, input logic [15:0] p, input logic [5:0] d);
        logic [4:0] lo;
        logic [15:0] ea;
        logic [15:0] pn;
        lo = PTR_FIRST_LO_IDX + {2'b00, sel, 1'b0};
        pn = (md == PM_POST_INC) ? p + 16'h0001 : (md == PM_PRE_DEC) ? p - 16'h0001 : p;
        ea = (md == PM_PRE_DEC) ? pn : p + {10'h000, d};
        immediate_load(5'h03, 8'h96);
        set_ptr(lo, p);
        ptr_sel = sel;
        ptr_mode = md;
        disp = d;
        issue(op, 5'h02, 5'h03, 8'h00);
        check("strobe", {15'h0000, st ? s_we : s_re}, 16'h0001);
        check("address", s_dadr, ea);
        check("cycles", cyc, 16'h0002);
        if (st) check("store data", {8'h00, s_wd}, 16'h0096);
        else begin
            peek(5'h02);
            check("load data", {8'h00, pv}, {8'h00, ea[7:0] ^ 8'h5a});
        end
        check_ptr(lo, pn);
    endtask : t_mem

    task automatic t_direct;
        direct_addr = 16'h1234;
        issue(OP_DIRECT_LOAD, 5'h04, 5'h00, 8'h00);
        check("direct load", {s_re, cyc[2:0], s_dadr[11:0]}, 16'ha234);
        peek(5'h04);
        check("direct data", {8'h00, pv}, 16'h006e);
        direct_addr = 16'h4321;
        issue(OP_DIRECT_STORE, 5'h00, 5'h03, 8'h00);
        check("direct store", {s_we, cyc[2:0], s_dadr[11:0]}, 16'ha321);
        check("direct wdata", {8'h00, s_wd}, 16'h0096);
    endtask : t_direct

    task automatic t_pm;
        set_ptr(PTR_THIRD_LO_IDX, 16'h0456);
        ptr_mode = PM_POST_INC;
        use_register_zero = 1'b0;
        issue(OP_PROGRAM_MEMORY_READ, 5'h05, 5'h00, 8'h00);
        check("pm read", {s_pre, cyc[2:0], s_padr[11:0]}, 16'hb456);
        peek(5'h05);
        check("pm data", {8'h00, pv}, 16'h0091);
        check_ptr(PTR_THIRD_LO_IDX, 16'h0457);
        ptr_mode = PM_PLAIN;
        use_register_zero = 1'b1;
        issue(OP_PROGRAM_MEMORY_READ, 5'h05, 5'h00, 8'h00);
        peek(REGISTER_ZERO_IDX);
        check("pm data zero", {8'h00, pv}, 16'h0090);
        immediate_load(REGISTER_ZERO_IDX, 8'h11);
        immediate_load(REGISTER_ONE_IDX, 8'h22);
        issue(OP_PROGRAM_MEMORY_WRITE, 5'h00, 5'h00, 8'h00);
        check("pm write", {s_pwe, s_padr[14:0]}, 16'h8457);
        check("pm wdata", s_pwd, 16'h2211);
        check("pm busy wait", {15'h0000, cyc >= 16'(2 + PM_BUSY)}, 16'h0001);
    endtask : t_pm

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst, op_valid, use_register_zero, flag_overflow, flag_irq_enable} = 5'b10000;
        {op_code, ptr_sel, ptr_mode} = {OP_NOP, PTR_FIRST, PM_PLAIN};
        {dst_idx, src_idx, peek_idx, imm_byte, br_offset, disp} = '0;
        {direct_addr, exp_pc, jmp} = '0;
        repeat (10) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        check("reset pc", pc, PC_RESET);
        t_branch();
        t_move();
        t_mem(1'b0, OP_INDIRECT_LOAD, PTR_FIRST, PM_PLAIN, 16'h0120, 6'h00);
        t_mem(1'b0, OP_INDIRECT_LOAD, PTR_FIRST, PM_POST_INC, 16'hffff, 6'h00);
        t_mem(1'b0, OP_INDIRECT_LOAD, PTR_SECOND, PM_PRE_DEC, 16'h0000, 6'h00);
        t_mem(1'b0, OP_INDIRECT_LOAD, PTR_THIRD, PM_POST_INC, 16'h0230, 6'h00);
        t_mem(1'b0, OP_DISPLACEMENT_LOAD, PTR_SECOND, PM_PLAIN, 16'h0100, 6'h3f);
        t_mem(1'b0, OP_DISPLACEMENT_LOAD, PTR_THIRD, PM_PLAIN, 16'h00f0, 6'h20);
        t_direct();
        t_mem(1'b1, OP_INDIRECT_STORE, PTR_FIRST, PM_PRE_DEC, 16'h0301, 6'h00);
        t_mem(1'b1, OP_INDIRECT_STORE, PTR_SECOND, PM_POST_INC, 16'h0040, 6'h00);
        t_mem(1'b1, OP_INDIRECT_STORE, PTR_THIRD, PM_PLAIN, 16'h0050, 6'h00);
        t_mem(1'b1, OP_DISPLACEMENT_STORE, PTR_THIRD, PM_PLAIN, 16'h0060, 6'h01);
        t_pm();
        conclude();
    end
endmodule : data_transfer_branch_exec_tb

`default_nettype wire

// ==== testbench/mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// Data memory and program memory on the far side of the unit
module mem_model #(
    parameter int PM_BUSY = 3
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Data memory
    input wire logic [15:0] dm_addr,
    input wire logic [7:0] dm_wdata,
    input wire logic dm_we,
    input wire logic dm_re,
    output logic [7:0] dm_rdata,
    // Program memory
    input wire logic [15:0] pm_addr,
    input wire logic pm_re,
    input wire logic pm_we,
    output logic [7:0] pm_rdata,
    output logic pm_busy
);
    logic [7:0] mem_q [256]; // Data bytes by low address byte
    logic [7:0] last_q = 8'h00; // Last data byte returned
    logic [7:0] pm_q = 8'h00; // Registered program byte
    int busy_q = 0; // Write busy countdown

    // Data only while the read strobe is up, the inverse otherwise
    assign dm_rdata = dm_re ? mem_q[dm_addr[7:0]] : ~last_q;
    assign pm_rdata = pm_q;
    assign pm_busy = (busy_q != 0);

    // Contents start as a pattern of the address
    initial begin
        for (int i = 0; i < 256; i++) mem_q[i] = 8'(i) ^ 8'h5a;
    end

    // Writes, synchronous program read and busy countdown
    always @(posedge sys_clk) begin
        if (dm_re) last_q <= mem_q[dm_addr[7:0]];
        if (dm_we) mem_q[dm_addr[7:0]] <= dm_wdata;
        pm_q <= pm_re ? (pm_addr[7:0] ^ pm_addr[15:8] ^ 8'hc3) : ~pm_q;
        if (rst) busy_q <= 0;
        else if (pm_we) busy_q <= PM_BUSY;
        else if (busy_q != 0) busy_q <= busy_q - 1;
    end
endmodule : mem_model

`default_nettype wire
